// file: arb_alu_params.svh
// Register indices, field positions and reset values of the arbiter level and ALU flag bank.
`ifndef ARB_ALU_PARAMS_SVH
`define ARB_ALU_PARAMS_SVH
`define IDX_W            12
`define IDX_LOCK         12'h0B4
`define IDX_SCAN         12'h0B5
`define IDX_DMA1         12'h0B6
`define IDX_DMA2         12'h0B7
`define IDX_DMA3         12'h0B8
`define IDX_DMA4         12'h0B9
`define IDX_MAIN         12'h0BE
`define IDX_IRQ          12'h0BF
`define IDX_FLAGS        12'h4D8
`define IDX_MULTIPLY_RESULT         12'h4F3
`define IDX_MULTIPLY_RESULT_HI      12'h4F4
`define LVL_W            3
`define LVL_RST          3'h0
`define LOCK_BIT         0
`define FLAG_C           0
`define FLAG_DC          1
`define FLAG_Z           2
`define FLAG_OV          3
`define FLAG_N           4
`define FLAG_PD          5
`define FLAG_TO          6
`define FLAGS_RST        8'h60
`define FLAGS_SW_MASK    8'h1F
`define MULTIPLY_RESULT_RST         16'h0000
`endif

// file: arb_alu_pkg.sv
// Types shared by the arbiter level and ALU flag register bank.
package arb_alu_pkg;
  typedef enum logic [2:0] {
    OP_ADD,
    OP_SUB,
    OP_AND,
    OP_RLC,
    OP_RRC
  } alu_op_t;
  typedef enum logic [2:0] {
    LV_SCAN,
    LV_DMA1,
    LV_DMA2,
    LV_DMA3,
    LV_DMA4,
    LV_MAIN,
    LV_IRQ
  } lvl_sel_t;
endpackage

// file: arb_alu_regs.sv
// APB register bank holding bus arbiter levels, their lock, the ALU flags and the product.
//
// How it works
// [RULE_01] Interrupt routine arbiter level, three bits.
// [RULE_02] Main routine arbiter level, three bits.
// [RULE_03] Four DMA channel arbiter levels.
// [RULE_04] Memory scanner arbiter level, three bits.
// [RULE_05] Level value maps directly; zero highest.
// [RULE_06] Lock set: level writes are ignored.
// [RULE_07] Lock clear: level writes are accepted.
// [RULE_08] Lock changes only right after unlock.
// [RULE_09] One-shot config: lock cannot clear; reset clears.
// [RULE_10] Sixteen-bit product, whole or byte access.
// [RULE_11] Expiry flag set by power-up, kick, sleep.
// [RULE_12] Expiry flag cleared by watchdog time-out.
// [RULE_13] Sleep flag set by power-up, kick; sleep clears.
// [RULE_14] Sign flag follows result bit seven.
// [RULE_15] Wrap flag marks signed overflow.
// [RULE_16] Zero flag marks all-clear result.
// [RULE_17] Nibble carry from bit three on add/sub.
// [RULE_18] Carry from bit seven on add/sub.
// [RULE_19] Subtract adds complement; carries are inverted borrows.
// [RULE_20] Rotate through carry loads shifted-out bit.
// [RULE_21] Power-on reset sets flag defaults; warm resets keep.
// [RULE_22] Flag register as destination drops the result.
// [RULE_23] Unused upper bits ignore writes, read zero.
`timescale 1ns/100ps
`include "arb_alu_params.svh"
module arb_alu_regs #(
  parameter int ADDR_W = 14
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              warm_reset,
  input  wire logic              unlock_armed,
  input  wire logic              one_shot_lock_cfg,
  input  wire logic              watchdog_kick_op,
  input  wire logic              sleep_op,
  input  wire logic              watchdog_timeout,
  input  wire logic              alu_valid,
  input  wire arb_alu_pkg::alu_op_t alu_op,
  input  wire logic [7:0]        alu_a,
  input  wire logic [7:0]        alu_b,
  input  wire logic              alu_to_flags,
  input  wire logic              mul_valid,
  input  wire logic [15:0]       mul_product,
  output logic      [2:0]        irq_arb_level,
  output logic      [2:0]        main_arb_level,
  output logic      [2:0]        dma1_arb_level,
  output logic      [2:0]        dma2_arb_level,
  output logic      [2:0]        dma3_arb_level,
  output logic      [2:0]        dma4_arb_level,
  output logic      [2:0]        scanner_arb_level,
  output logic                   arb_level_lock_bit,
  output logic      [7:0]        alu_flags,
  output logic      [15:0]       multiply_result,
  output logic      [7:0]        alu_result,
  output logic                   alu_result_valid
);
  import arb_alu_pkg::*;

  localparam int NLVL = 7;

  logic [`LVL_W-1:0] lvl_r   [NLVL];
  logic [`LVL_W-1:0] lvl_nxt [NLVL];
  logic              lock_r;
  logic              lock_nxt;
  logic [7:0]        flags_r;
  logic [7:0]        flags_nxt;
  logic [15:0]       multiply_result_r;
  logic [15:0]       multiply_result_nxt;
  logic [7:0]        res_r;
  logic [7:0]        res_nxt;
  logic              resv_r;
  logic              resv_nxt;
  logic [31:0]       rdata_r;
  logic [31:0]       rdata_nxt;
  logic              err_r;
  logic              err_nxt;

  logic [`IDX_W-1:0] idx;
  logic              aligned;
  logic              setup;
  logic              wr_acc;

  // Maps a register index to a level slot; returns the slot and a hit flag.
  function automatic logic [3:0] lvl_decode(input logic [`IDX_W-1:0] i);
    logic [3:0] r;
    r = 4'h0;
    case (i)
      `IDX_SCAN: r = {1'b1, 3'(LV_SCAN)};
      `IDX_DMA1: r = {1'b1, 3'(LV_DMA1)};
      `IDX_DMA2: r = {1'b1, 3'(LV_DMA2)};
      `IDX_DMA3: r = {1'b1, 3'(LV_DMA3)};
      `IDX_DMA4: r = {1'b1, 3'(LV_DMA4)};
      `IDX_MAIN: r = {1'b1, 3'(LV_MAIN)};
      `IDX_IRQ:  r = {1'b1, 3'(LV_IRQ)};
      default:   r = 4'h0;
    endcase
    return r;
  endfunction

  function automatic logic mapped(input logic [`IDX_W-1:0] i);
    return lvl_decode(i)[3] || i == `IDX_LOCK || i == `IDX_FLAGS ||
           i == `IDX_MULTIPLY_RESULT || i == `IDX_MULTIPLY_RESULT_HI;
  endfunction

  assign idx     = paddr[ADDR_W-1:2];
  assign aligned = paddr[1:0] == 2'b00;
  assign setup   = psel && !penable;
  assign wr_acc  = psel && penable && pwrite && !err_r;

  // Every transfer takes one access cycle; read data is captured in setup.
  assign pready  = psel && penable;
  assign prdata  = rdata_r;
  assign pslverr = psel && penable && err_r;

  always_comb begin
    logic [3:0] d;
    d = lvl_decode(idx);
    rdata_nxt = rdata_r;
    err_nxt   = err_r;
    if (setup) begin
      err_nxt   = !aligned || !mapped(idx);
      rdata_nxt = 32'h0000_0000;
      if (aligned && d[3]) begin
        rdata_nxt[`LVL_W-1:0] = lvl_r[d[2:0]]; // see [RULE_23]
      end else if (aligned) begin
        case (idx)
          `IDX_LOCK:    rdata_nxt[`LOCK_BIT] = lock_r; // see [RULE_23]
          `IDX_FLAGS:   rdata_nxt[7:0] = flags_r;
          `IDX_MULTIPLY_RESULT:    rdata_nxt[15:0] = multiply_result_r; // see [RULE_10]
          `IDX_MULTIPLY_RESULT_HI: rdata_nxt[7:0] = multiply_result_r[15:8];
          default:      rdata_nxt = 32'h0000_0000;
        endcase
      end
    end
  end

  // Arbiter levels and their lock.
  always_comb begin
    logic [3:0] d;
    d = lvl_decode(idx);
    for (int k = 0; k < NLVL; k++) begin
      lvl_nxt[k] = lvl_r[k];
    end
    lock_nxt = lock_r;
    if (wr_acc && pstrb[0] && d[3] && !lock_r) begin // see [RULE_06] [RULE_07]
      lvl_nxt[d[2:0]] = pwdata[`LVL_W-1:0]; // see [RULE_23]
    end
    if (wr_acc && pstrb[0] && idx == `IDX_LOCK && unlock_armed) begin // see [RULE_08]
      if (pwdata[`LOCK_BIT]) begin
        lock_nxt = 1'b1;
      end else if (!(one_shot_lock_cfg && lock_r)) begin // see [RULE_09]
        lock_nxt = 1'b0;
      end
    end
    // A warm reset reopens the lock so one more set is possible.
    if (warm_reset) begin
      lock_nxt = 1'b0; // see [RULE_09]
    end
  end

  // Flags and ALU result.
  always_comb begin
    logic [7:0] bb;
    logic [8:0] sum;
    logic [4:0] lo;
    logic [7:0] r;
    logic [7:0] upd;
    logic [7:0] mask;
    bb   = alu_b;
    sum  = 9'h000;
    lo   = 5'h00;
    r    = 8'h00;
    upd  = 8'h00;
    mask = 8'h00;
    flags_nxt = flags_r;
    res_nxt   = res_r;
    resv_nxt  = 1'b0;
    case (alu_op)
      OP_ADD, OP_SUB: begin
        // Subtraction adds the complement, so a set carry means no borrow.
        bb  = (alu_op == OP_SUB) ? ~alu_b : alu_b; // see [RULE_19]
        sum = {1'b0, alu_a} + {1'b0, bb} + {8'h00, alu_op == OP_SUB};
        lo  = {1'b0, alu_a[3:0]} + {1'b0, bb[3:0]} + {4'h0, alu_op == OP_SUB};
        r   = sum[7:0];
        upd[`FLAG_C]  = sum[8]; // see [RULE_18]
        upd[`FLAG_DC] = lo[4]; // see [RULE_17]
        upd[`FLAG_OV] = (alu_a[7] == bb[7]) && (r[7] != alu_a[7]); // see [RULE_15]
        mask = 8'h1F;
      end
      OP_RLC: begin
        r = {alu_a[6:0], flags_r[`FLAG_C]};
        upd[`FLAG_C] = alu_a[7]; // see [RULE_20]
        mask = 8'h15;
      end
      OP_RRC: begin
        r = {flags_r[`FLAG_C], alu_a[7:1]};
        upd[`FLAG_C] = alu_a[0]; // see [RULE_20]
        mask = 8'h15;
      end
      OP_AND: begin
        r = alu_a & alu_b;
        mask = 8'h14;
      end
      default: begin
        r    = 8'h00;
        mask = 8'h00;
      end
    endcase
    upd[`FLAG_N] = r[7]; // see [RULE_14]
    upd[`FLAG_Z] = r == 8'h00; // see [RULE_16]
    if (wr_acc && pstrb[0] && idx == `IDX_FLAGS) begin
      flags_nxt = (flags_r & ~`FLAGS_SW_MASK) | (pwdata[7:0] & `FLAGS_SW_MASK);
    end
    // The ALU update is applied after the bus write so hardware wins a clash.
    if (alu_valid) begin
      flags_nxt = (flags_nxt & ~mask) | (upd & mask);
      if (!alu_to_flags) begin // see [RULE_22]
        res_nxt  = r;
        resv_nxt = 1'b1;
      end
    end
    if (watchdog_timeout) begin
      flags_nxt[`FLAG_TO] = 1'b0; // see [RULE_12]
    end
    if (sleep_op) begin
      flags_nxt[`FLAG_TO] = 1'b1; // see [RULE_11]
      flags_nxt[`FLAG_PD] = 1'b0; // see [RULE_13]
    end
    if (watchdog_kick_op) begin
      flags_nxt[`FLAG_TO] = 1'b1; // see [RULE_11]
      flags_nxt[`FLAG_PD] = 1'b1; // see [RULE_13]
    end
  end

  // Product register; the multiplier wins over a bus write in the same cycle.
  always_comb begin
    multiply_result_nxt = multiply_result_r;
    if (wr_acc && idx == `IDX_MULTIPLY_RESULT) begin // see [RULE_10]
      if (pstrb[0]) begin
        multiply_result_nxt[7:0] = pwdata[7:0];
      end
      if (pstrb[1]) begin
        multiply_result_nxt[15:8] = pwdata[15:8];
      end
    end
    if (wr_acc && pstrb[0] && idx == `IDX_MULTIPLY_RESULT_HI) begin
      multiply_result_nxt[15:8] = pwdata[7:0];
    end
    if (mul_valid) begin
      multiply_result_nxt = mul_product;
    end
  end

  // The async reset is power-on/brown-out; warm resets do not touch the flags.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < NLVL; k++) begin
        lvl_r[k] <= `LVL_RST;
      end
      lock_r  <= 1'b0;
      flags_r <= `FLAGS_RST; // see [RULE_21]
      multiply_result_r  <= `MULTIPLY_RESULT_RST;
      res_r   <= 8'h00;
      resv_r  <= 1'b0;
      rdata_r <= 32'h0000_0000;
      err_r   <= 1'b0;
    end else begin
      for (int k = 0; k < NLVL; k++) begin
        lvl_r[k] <= lvl_nxt[k];
      end
      lock_r  <= lock_nxt;
      flags_r <= flags_nxt;
      multiply_result_r  <= multiply_result_nxt;
      res_r   <= res_nxt;
      resv_r  <= resv_nxt;
      rdata_r <= rdata_nxt;
      err_r   <= err_nxt;
    end
  end

  // Levels go straight out as binary, zero being the most urgent.
  assign scanner_arb_level  = lvl_r[LV_SCAN]; // see [RULE_04] [RULE_05]
  assign dma1_arb_level     = lvl_r[LV_DMA1]; // see [RULE_03]
  assign dma2_arb_level     = lvl_r[LV_DMA2];
  assign dma3_arb_level     = lvl_r[LV_DMA3];
  assign dma4_arb_level     = lvl_r[LV_DMA4];
  assign main_arb_level     = lvl_r[LV_MAIN]; // see [RULE_02]
  assign irq_arb_level      = lvl_r[LV_IRQ]; // see [RULE_01]
  assign arb_level_lock_bit = lock_r;
  assign alu_flags          = flags_r;
  assign multiply_result    = multiply_result_r;
  assign alu_result         = res_r;
  assign alu_result_valid   = resv_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_lvl_write;
    wr_acc && pstrb[0] && lvl_decode(idx)[3] && !warm_reset;
  endsequence

  sequence s_lock_write;
    wr_acc && pstrb[0] && idx == `IDX_LOCK;
  endsequence

  a_locked_level_hold: assert property ( // see [RULE_06]
    s_lvl_write and lock_r |=> $stable(main_arb_level) && $stable(irq_arb_level) && $stable(scanner_arb_level)
    && $stable(dma1_arb_level) && $stable(dma2_arb_level) && $stable(dma3_arb_level) && $stable(dma4_arb_level))
    else $error("Level changed while locked.");
  a_open_level_lands: assert property ( // see [RULE_07] [RULE_02]
    s_lvl_write and !lock_r && idx == `IDX_MAIN |=> main_arb_level == $past(pwdata[2:0]))
    else $error("Open level write did not land.");
  a_irq_level_lands: assert property ( // see [RULE_01]
    s_lvl_write and !lock_r && idx == `IDX_IRQ |=> irq_arb_level == $past(pwdata[2:0]))
    else $error("Interrupt level write did not land.");
  a_dma_level_lands: assert property ( // see [RULE_03]
    s_lvl_write and !lock_r && idx == `IDX_DMA4 |=> dma4_arb_level == $past(pwdata[2:0]))
    else $error("DMA level write did not land.");
  a_scan_level_lands: assert property ( // see [RULE_04] [RULE_05]
    s_lvl_write and !lock_r && idx == `IDX_SCAN |=> scanner_arb_level == $past(pwdata[2:0]))
    else $error("Scanner level write did not land.");
  a_lock_needs_unlock: assert property ( // see [RULE_08]
    s_lock_write and !unlock_armed && !warm_reset |=> $stable(lock_r))
    else $error("Lock changed without unlock.");
  a_one_shot_hold: assert property (one_shot_lock_cfg && lock_r && !warm_reset |=> lock_r) // see [RULE_09]
    else $error("One-shot lock was cleared.");
  a_warm_unlocks: assert property (warm_reset |=> !lock_r ##1 1) // see [RULE_09]
    else $error("Warm reset left lock set.");
  a_level_reads_low: assert property ( // see [RULE_23]
    setup && !pwrite && lvl_decode(idx)[3] |=> rdata_r[31:3] == 29'h0)
    else $error("Upper level bits not zero.");
  a_lock_reads_low: assert property ( // see [RULE_23]
    setup && !pwrite && idx == `IDX_LOCK |=> rdata_r[31:1] == 31'h0)
    else $error("Upper lock bits not zero.");
  a_kick_sets_both: assert property ( // see [RULE_11] [RULE_13]
    watchdog_kick_op |=> alu_flags[`FLAG_TO] && alu_flags[`FLAG_PD])
    else $error("Kick did not set both flags.");
  a_sleep_flags: assert property ( // see [RULE_11] [RULE_13]
    sleep_op && !watchdog_kick_op |=> alu_flags[`FLAG_TO] && !alu_flags[`FLAG_PD])
    else $error("Sleep flags wrong.");
  a_timeout_clears: assert property ( // see [RULE_12]
    watchdog_timeout && !sleep_op && !watchdog_kick_op |=> !alu_flags[`FLAG_TO])
    else $error("Time-out did not clear flag.");
  a_warm_keeps_flags: assert property ( // see [RULE_21]
    warm_reset && !alu_valid && !sleep_op && !watchdog_kick_op && !watchdog_timeout
    && !(wr_acc && idx == `IDX_FLAGS) |=> $stable(alu_flags))
    else $error("Warm reset disturbed the flags.");
  a_zero_tracks: assert property ( // see [RULE_14] [RULE_16]
    alu_valid && !alu_to_flags |=> alu_flags[`FLAG_Z] == (alu_result == 8'h00)
    && alu_flags[`FLAG_N] == alu_result[7])
    else $error("Zero or sign flag wrong.");
  a_add_wrap: assert property ( // see [RULE_15]
    alu_valid && alu_op == OP_ADD && !alu_to_flags |=> alu_flags[`FLAG_OV] ==
    ($past(alu_a[7]) == $past(alu_b[7]) && alu_result[7] != $past(alu_a[7])))
    else $error("Wrap flag wrong on add.");
  a_add_nibble_carry: assert property ( // see [RULE_17]
    alu_valid && alu_op == OP_ADD |=> alu_flags[`FLAG_DC] ==
    (({1'b0, $past(alu_a[3:0])} + {1'b0, $past(alu_b[3:0])}) > 5'h0F))
    else $error("Nibble carry wrong on add.");
  a_add_carry: assert property ( // see [RULE_18]
    alu_valid && alu_op == OP_ADD |=> alu_flags[`FLAG_C] ==
    (({1'b0, $past(alu_a)} + {1'b0, $past(alu_b)}) > 9'h0FF))
    else $error("Carry wrong on add.");
  a_sub_no_borrow: assert property ( // see [RULE_19] [RULE_18]
    alu_valid && alu_op == OP_SUB && alu_a >= alu_b |=> alu_flags[`FLAG_C])
    else $error("Borrow flag inverted wrongly.");
  a_rlc_carry: assert property ( // see [RULE_20]
    alu_valid && alu_op == OP_RLC |=> alu_flags[`FLAG_C] == $past(alu_a[7]))
    else $error("Rotate carry wrong.");
  a_rrc_carry: assert property ( // see [RULE_20]
    alu_valid && alu_op == OP_RRC |=> alu_flags[`FLAG_C] == $past(alu_a[0]))
    else $error("Right rotate carry wrong.");
  a_product_load: assert property (mul_valid |=> multiply_result == $past(mul_product)) // see [RULE_10]
    else $error("Product not loaded.");
  a_flag_dest_drop: assert property ( // see [RULE_22]
    alu_valid && alu_to_flags |=> !alu_result_valid && $stable(alu_result))
    else $error("Result written to flags target.");
endmodule

// file: arbiter_priority_and_alu_flags_tb_top.sv
// Self-checking testbench for the arbiter level, lock, ALU flag and product register bank.
`timescale 1ns/100ps
`include "arb_alu_params.svh"
module arbiter_priority_and_alu_flags_tb_top;
  import arb_alu_pkg::*;
  typedef struct packed {alu_op_t op; logic [7:0] a; logic [7:0] b; logic [7:0] res; logic [4:0] fl;} row_t;
  localparam logic [13:0] A_LOCK = {`IDX_LOCK, 2'h0};
  localparam logic [13:0] A_FLAG = {`IDX_FLAGS, 2'h0};
  localparam logic [13:0] A_MULTIPLY_RESULT = {`IDX_MULTIPLY_RESULT, 2'h0};
  localparam logic [13:0] A_PHI  = {`IDX_MULTIPLY_RESULT_HI, 2'h0};
  localparam logic [13:0] A_IRQ  = {`IDX_IRQ, 2'h0};
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'h0;
  logic        warm_reset = 1'h0, unlock_armed = 1'h0, one_shot_lock_cfg = 1'h0, watchdog_kick_op = 1'h0;
  logic        sleep_op = 1'h0, watchdog_timeout = 1'h0, alu_valid = 1'h0, alu_to_flags = 1'h0, mul_valid = 1'h0;
  alu_op_t     alu_op = OP_ADD;
  logic [7:0]  alu_a = 8'h00, alu_b = 8'h00;
  logic [15:0] mul_product = 16'h0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, arb_level_lock_bit, alu_result_valid, er;
  logic [2:0]  lvl [7];
  logic [7:0]  alu_flags, alu_result;
  logic [15:0] multiply_result;
  int          err_total = 0, checks = 0, cyc = 0;
  logic [13:0] la [7] = '{{`IDX_SCAN, 2'h0}, {`IDX_DMA1, 2'h0}, {`IDX_DMA2, 2'h0}, {`IDX_DMA3, 2'h0},
                         {`IDX_DMA4, 2'h0}, {`IDX_MAIN, 2'h0}, A_IRQ};
  // Flags are carried over between rows: logic and rotate ops leave the other flags alone.
  row_t        rows [8] = '{'{OP_ADD, 8'h7F, 8'h01, 8'h80, 5'h1A}, '{OP_ADD, 8'hFF, 8'h01, 8'h00, 5'h07},
                            '{OP_SUB, 8'h00, 8'h01, 8'hFF, 5'h10}, '{OP_SUB, 8'h80, 8'h01, 8'h7F, 5'h09},
                            '{OP_AND, 8'hF0, 8'h0F, 8'h00, 5'h0D}, '{OP_RLC, 8'h80, 8'h00, 8'h01, 5'h09},
                            '{OP_RRC, 8'h02, 8'h00, 8'h81, 5'h18}, '{OP_RRC, 8'h01, 8'h00, 8'h00, 5'h0D}};

  arb_alu_regs #(.ADDR_W(14)) arb_alu_regs_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .warm_reset(warm_reset), .unlock_armed(unlock_armed), .one_shot_lock_cfg(one_shot_lock_cfg),
    .watchdog_kick_op(watchdog_kick_op), .sleep_op(sleep_op), .watchdog_timeout(watchdog_timeout),
    .alu_valid(alu_valid), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b), .alu_to_flags(alu_to_flags),
    .mul_valid(mul_valid), .mul_product(mul_product), .irq_arb_level(lvl[6]), .main_arb_level(lvl[5]),
    .dma1_arb_level(lvl[1]), .dma2_arb_level(lvl[2]), .dma3_arb_level(lvl[3]), .dma4_arb_level(lvl[4]),
    .scanner_arb_level(lvl[0]), .arb_level_lock_bit(arb_level_lock_bit), .alu_flags(alu_flags),
    .multiply_result(multiply_result), .alu_result(alu_result), .alu_result_valid(alu_result_valid));

  always #50 pclk = ~pclk;

  // The whole run needs well under a thousand cycles, so this ceiling only trips on a hang.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      $display("ERROR at %0t: run did not finish", $time);
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    // Only the bench timeout ends a wait for a slave that never answers.
    while (pready !== 1'h1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    #1;
  endtask

  task automatic rdchk(input logic [13:0] a, input logic [31:0] exp, input string what);
    apb(1'h0, a, 32'h0000_0000, 4'h0);
    chk(rd, exp, what);
  endtask

  task automatic alu(input alu_op_t op, input logic [7:0] a, input logic [7:0] b, input logic to_f);
    @(posedge pclk);
    alu_valid <= 1'h1;
    alu_op <= op;
    alu_a <= a;
    alu_b <= b;
    alu_to_flags <= to_f;
    @(posedge pclk);
    alu_valid <= 1'h0;
    alu_to_flags <= 1'h0;
    #1;
  endtask

  task automatic ev(input int k);
    @(posedge pclk);
    case (k)
      0: sleep_op <= 1'h1;
      1: watchdog_timeout <= 1'h1;
      2: watchdog_kick_op <= 1'h1;
      3: warm_reset <= 1'h1;
      default: mul_valid <= 1'h1;
    endcase
    @(posedge pclk);
    {sleep_op, watchdog_timeout, watchdog_kick_op, warm_reset, mul_valid} <= 5'h00;
    #1;
  endtask

  task automatic lock_wr(input logic [31:0] d, input logic exp);
    apb(1'h1, A_LOCK, d, 4'hF);
    chk(32'(arb_level_lock_bit), 32'(exp), "lock bit");
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    #1;
    chk(32'(alu_flags), 32'h0000_0060, "flags after reset");
    chk(32'(multiply_result), 32'h0000_0000, "product after reset");
    rdchk(A_FLAG, 32'h0000_0060, "flags read");
    for (int i = 0; i < 7; i++) begin
      rdchk(la[i], 32'h0000_0000, "level reset");
      apb(1'h1, la[i], 32'hFFFF_FFF8 | 32'(i + 1), 4'hF);
      rdchk(la[i], 32'(i + 1), "level read, upper bits zero");
      chk(32'(lvl[i]), 32'(i + 1), "level port");
    end
    for (int i = 0; i < 8; i++) begin
      alu(rows[i].op, rows[i].a, rows[i].b, 1'h0);
      chk(32'(alu_result), 32'(rows[i].res), "alu result");
      chk(32'(alu_result_valid), 32'h0000_0001, "alu valid");
      chk(32'(alu_flags), 32'({3'h3, rows[i].fl}), "alu flags");
    end
    alu(OP_ADD, 8'h7F, 8'h01, 1'h1);
    chk(32'(alu_result_valid), 32'h0000_0000, "result dropped");
    chk(32'(alu_flags), 32'h0000_007A, "flags as destination");
    ev(0);
    chk(32'(alu_flags[6:5]), 32'h0000_0002, "sleep");
    ev(1);
    chk(32'(alu_flags[6:5]), 32'h0000_0000, "watchdog time-out");
    ev(2);
    chk(32'(alu_flags[6:5]), 32'h0000_0003, "watchdog kick");
    apb(1'h1, A_FLAG, 32'h0000_00FF, 4'hF);
    rdchk(A_FLAG, 32'h0000_007F, "flags write keeps read-only bits");
    lock_wr(32'h0000_00FF, 1'h0);
    @(posedge pclk);
    unlock_armed <= 1'h1;
    lock_wr(32'h0000_00FF, 1'h1);
    rdchk(A_LOCK, 32'h0000_0001, "lock read");
    apb(1'h1, A_IRQ, 32'h0000_0000, 4'hF);
    chk(32'(lvl[6]), 32'h0000_0007, "locked level write");
    chk(32'(er), 32'h0000_0000, "locked write is silent");
    lock_wr(32'h0000_0000, 1'h0);
    apb(1'h1, A_IRQ, 32'h0000_0000, 4'hF);
    chk(32'(lvl[6]), 32'h0000_0000, "unlocked level write");
    lock_wr(32'h0000_0001, 1'h1);
    @(posedge pclk);
    one_shot_lock_cfg <= 1'h1;
    lock_wr(32'h0000_0000, 1'h1);
    ev(3);
    chk(32'(arb_level_lock_bit), 32'h0000_0000, "device reset clears lock");
    chk(32'(alu_flags), 32'h0000_007F, "warm reset keeps flags");
    lock_wr(32'h0000_0001, 1'h1);
    @(posedge pclk);
    unlock_armed <= 1'h0;
    mul_product <= 16'hBEEF;
    ev(4);
    chk(32'(multiply_result), 32'h0000_BEEF, "product load");
    rdchk(A_MULTIPLY_RESULT, 32'h0000_BEEF, "product read");
    apb(1'h1, A_MULTIPLY_RESULT, 32'h0000_1234, 4'h1);
    chk(32'(multiply_result), 32'h0000_BE34, "low byte write");
    rdchk(A_PHI, 32'h0000_00BE, "high byte read");
    apb(1'h1, A_PHI, 32'h0000_0056, 4'h1);
    chk(32'(multiply_result), 32'h0000_5634, "high byte write");
    apb(1'h1, A_MULTIPLY_RESULT, 32'h0000_A5C3, 4'h3);
    chk(32'(multiply_result), 32'h0000_A5C3, "whole product write");
    rdchk(14'h0000, 32'h0000_0000, "unmapped read");
    chk(32'(er), 32'h0000_0001, "unmapped error");
    rdchk(A_LOCK | 14'h0002, 32'h0000_0000, "misaligned read");
    chk(32'(er), 32'h0000_0001, "misaligned error");
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    #1;
    chk(32'(lvl[0]), 32'h0000_0000, "level after reset");
    chk(32'(arb_level_lock_bit), 32'h0000_0000, "lock after reset");
    chk(32'(alu_flags), 32'h0000_0060, "flags after second reset");
    report_and_stop();
  end
endmodule
